// ### inc/pir_map.svh
// command codes, byte counts, field positions and reset values of the identity bank
`ifndef PIR_MAP_SVH
`define PIR_MAP_SVH
`define PIR_CMD_MODEL 8'h9A
`define PIR_CMD_MAKER_REV 8'h9B
`define PIR_CMD_IC_ID 8'hAD
`define PIR_CMD_SI_REV 8'hAE
`define PIR_LEN_MODEL 8'h04
`define PIR_LEN_MAKER_REV 8'h01
`define PIR_LEN_IC_ID 8'h06
`define PIR_LEN_SI_REV 8'h01
`define PIR_LEN_NONE 8'h00
`define PIR_REV_DEV_MSB 3
`define PIR_REV_DEV_LSB 0
`define PIR_REV_PS_MSB 6
`define PIR_REV_PS_LSB 4
`define PIR_REV_UNUSED_BIT 7
`define PIR_MAKER_REV_RESET 8'h00
`define PIR_PAST_END_BYTE 8'hFF
`endif

// ### inc/pir_pkg.sv
// types shared by the identity bank and its pmbus byte engine
package pir_pkg;
	typedef enum logic [1:0] {PIR_IDLE, PIR_READ, PIR_WRITE, PIR_DROP} pir_state_t;
	typedef struct packed {
		logic start;
		logic is_read;
		logic [7:0] code;
	} pir_cmd_t;
	typedef struct packed {
		logic stb;
		logic [7:0] data;
	} pir_byte_t;
endpackage

// ### rtl/pir_identity.sv
// pmbus identification and revision command bank
`timescale 1ns/100ps
`include "pir_map.svh"

module pir_identity
	import pir_pkg::*;
#(
	parameter logic [23:0] PART_DIGITS = 24'h123456, // six part number digits, first in top nibble
	parameter logic [7:0] PART_EXT = 8'h00, // part number extension code
	parameter logic [15:0] MAKER_CODE = 16'h4241, // arbitrary ascii code, low byte sent first
	parameter int DEVICE_REV = 0 // silicon revision count
)
(
	input wire logic SYS_CLK, // 40 MHz clock
	input wire logic RSTN, // asynchronous reset, active low
	input wire pir_cmd_t CMD, // command start from the pmbus byte engine
	input wire pir_byte_t WR, // written byte, count byte first
	input wire logic RD_REQ, // request for the next read byte, count byte first
	input wire logic CMD_END, // stop condition, closes the transaction
	input wire logic [7:0] NVM_REV, // maker revision as held in non-volatile memory
	input wire logic [2:0] PS_DIE_ID, // power stage die identifier, from the other die
	output pir_byte_t RD, // read byte answer
	output logic UNSUP, // pulse: unsupported command or bad write
	output logic NVM_STORE, // pulse: store NVM_DATA into non-volatile memory
	output logic [7:0] NVM_DATA // maker revision value to store
);
	generate
		if (DEVICE_REV < 0 || DEVICE_REV > 15)
		begin : g_bad_rev
			$error("DEVICE_REV must fit four bits");
		end
	endgenerate

	localparam logic [3:0] DEV_REV4 = 4'(DEVICE_REV);
	localparam logic [31:0] MODEL_WORD = {PART_EXT, PART_DIGITS[7:0], PART_DIGITS[15:8],
		PART_DIGITS[23:16]};
	localparam logic [47:0] ID_BLOCK = {MODEL_WORD, MAKER_CODE};

	logic rst_meta;
	logic rst_n;
	logic [2:0] ps_meta;
	logic [2:0] ps_sync;
	logic nvm_loaded;
	logic [7:0] maker_rev;
	logic [7:0] next_maker_rev;
	logic next_nvm_loaded;
	pir_state_t state;
	pir_state_t next_state;
	logic [7:0] code;
	logic [7:0] next_code;
	logic [2:0] idx;
	logic [2:0] next_idx;
	logic [7:0] wr_count;
	logic [7:0] next_wr_count;
	logic [7:0] wr_data;
	logic [7:0] next_wr_data;
	pir_byte_t next_rd;
	logic next_unsup;
	logic next_store;
	logic [7:0] next_nvm_data;
	logic [7:0] si_rev;

	always_ff @(posedge SYS_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// the stage version comes off another die, so it is synchronised like a pin
	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ps_meta <= 3'h0;
			ps_sync <= 3'h0;
		end
		else
		begin
			ps_meta <= PS_DIE_ID;
			ps_sync <= ps_meta;
		end
	end

	always_comb
	begin
		si_rev = 8'h00;
		si_rev[`PIR_REV_UNUSED_BIT] = 1'b0;
		si_rev[`PIR_REV_PS_MSB:`PIR_REV_PS_LSB] = ps_sync;
		si_rev[`PIR_REV_DEV_MSB:`PIR_REV_DEV_LSB] = DEV_REV4;
	end

	function automatic logic [7:0] len_of(input logic [7:0] c);
		if (c == `PIR_CMD_MODEL)
			len_of = `PIR_LEN_MODEL;
		else if (c == `PIR_CMD_MAKER_REV)
			len_of = `PIR_LEN_MAKER_REV;
		else if (c == `PIR_CMD_IC_ID)
			len_of = `PIR_LEN_IC_ID;
		else if (c == `PIR_CMD_SI_REV)
			len_of = `PIR_LEN_SI_REV;
		else
			len_of = `PIR_LEN_NONE;
	endfunction

	// byte n of the block, index 0 being the byte count
	function automatic logic [7:0] byte_of(input logic [7:0] c, input logic [2:0] n,
		input logic [7:0] rev, input logic [7:0] srev);
		logic [2:0] k;
		k = n - 3'h1;
		if (n == 3'h0)
			byte_of = len_of(c);
		else if ({5'h00, n} > len_of(c))
			byte_of = `PIR_PAST_END_BYTE;
		else if (c == `PIR_CMD_MODEL)
			byte_of = MODEL_WORD[k[1:0] * 8 +: 8];
		else if (c == `PIR_CMD_IC_ID)
			byte_of = ID_BLOCK[k * 8 +: 8];
		else if (c == `PIR_CMD_MAKER_REV)
			byte_of = rev;
		else
			byte_of = srev;
	endfunction

	always_comb
	begin
		next_state = state;
		next_code = code;
		next_idx = idx;
		next_wr_count = wr_count;
		next_wr_data = wr_data;
		next_rd.stb = 1'b0;
		next_rd.data = RD.data;
		next_unsup = 1'b0;
		next_store = 1'b0;
		next_nvm_data = NVM_DATA;
		next_maker_rev = maker_rev;
		next_nvm_loaded = 1'b1;
		if (!nvm_loaded)
			next_maker_rev = NVM_REV;
		if (CMD.start)
		begin
			next_code = CMD.code;
			next_idx = 3'h0;
			next_wr_count = 8'h00;
			if (len_of(CMD.code) == `PIR_LEN_NONE)
			begin
				next_state = PIR_DROP;
				next_unsup = 1'b1;
			end
			else if (CMD.is_read)
				next_state = PIR_READ;
			else if (CMD.code == `PIR_CMD_MAKER_REV)
				next_state = PIR_WRITE;
			else
			begin
				next_state = PIR_DROP;
				next_unsup = 1'b1;
			end
		end
		else
		begin
			case (state)
				PIR_READ:
				begin
					if (RD_REQ)
					begin
						next_rd.stb = 1'b1;
						next_rd.data = byte_of(code, idx, maker_rev, si_rev);
						if (idx != 3'h7)
							next_idx = idx + 3'h1;
					end
					if (CMD_END)
						next_state = PIR_IDLE;
				end
				PIR_WRITE:
				begin
					if (WR.stb)
					begin
						if (idx == 3'h0)
							next_wr_count = WR.data;
						else if (idx == 3'h1)
							next_wr_data = WR.data;
						if (idx != 3'h7)
							next_idx = idx + 3'h1;
					end
					// only a complete one-byte block commits, anything else is refused
					if (CMD_END)
					begin
						next_state = PIR_IDLE;
						if (idx == 3'h2 && wr_count == `PIR_LEN_MAKER_REV)
						begin
							next_maker_rev = wr_data;
							next_nvm_data = wr_data;
							next_store = 1'b1;
						end
						else
							next_unsup = 1'b1;
					end
				end
				PIR_DROP:
				begin
					if (CMD_END)
						next_state = PIR_IDLE;
				end
				default:
				begin
					next_state = PIR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= PIR_IDLE;
			code <= 8'h00;
			idx <= 3'h0;
			wr_count <= 8'h00;
			wr_data <= 8'h00;
			RD <= '0;
			UNSUP <= 1'b0;
			NVM_STORE <= 1'b0;
			NVM_DATA <= `PIR_MAKER_REV_RESET;
			maker_rev <= `PIR_MAKER_REV_RESET;
			nvm_loaded <= 1'b0;
		end
		else
		begin
			state <= next_state;
			code <= next_code;
			idx <= next_idx;
			wr_count <= next_wr_count;
			wr_data <= next_wr_data;
			RD <= next_rd;
			UNSUP <= next_unsup;
			NVM_STORE <= next_store;
			NVM_DATA <= next_nvm_data;
			maker_rev <= next_maker_rev;
			nvm_loaded <= next_nvm_loaded;
		end
	end
endmodule

// ### testbench/pir_identity_properties.sv
// port assertions for the identity bank
`timescale 1ns/100ps
module pir_identity_props
	import pir_pkg::*;
(
	input wire logic SYS_CLK, // clock
	input wire logic RSTN, // reset
	input wire pir_cmd_t CMD, // start
	input wire logic RD_REQ, // read ask
	input wire logic CMD_END, // stop
	input wire pir_byte_t RD, // answer
	input wire logic UNSUP, // refusal
	input wire logic NVM_STORE // store
);
	logic [7:0] c;
	logic [3:0] n;
	logic a;
	wire rw = CMD.start & ~CMD.is_read & (CMD.code inside {8'h9A, 8'hAD, 8'hAE});
	wire rv = RD.stb & n == 4'h1 & c == 8'hAE;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	always_ff @(posedge SYS_CLK or negedge RSTN)
		if (!RSTN)
			{c, n, a} <= '0;
		else if (CMD.start)
			// an unknown code never answers, so it does not open a read
			{c, n, a} <= {CMD.code, 4'h0,
				CMD.is_read & (CMD.code inside {8'h9A, 8'h9B, 8'hAD, 8'hAE})};
		else
			{n, a} <= {n + {3'h0, RD.stb}, a & ~CMD_END};
	a_count_byte: assert property (RD.stb && n == 4'h0 |->
		RD.data == (c == 8'h9A ? 8'h04 : c == 8'hAD ? 8'h06 : 8'h01)) else $error("bad count");
	a_rev_top: assert property (rv |-> !RD.data[7]) else $error("rev bit 7 set");
	a_rev_first: assert property (rv |-> RD.data[3:0] == 4'h0) else $error("rev not 0");
	a_read_answer: assert property (RD_REQ && a && !CMD.start |=> RD.stb)
		else $error("no answer");
	a_read_cause: assert property (RD.stb |-> $past(RD_REQ)) else $error("stray byte");
	a_ro_refuse: assert property (rw |=> UNSUP ##1 (!UNSUP || $past(CMD.start)))
		else $error("no refusal");
	a_ro_keep: assert property (rw |=> !NVM_STORE [*4]) else $error("ro store");
	a_store_cause: assert property (NVM_STORE |-> $past(CMD_END) && c == 8'h9B)
		else $error("bad store");
	c_store: cover property (NVM_STORE);
	c_refuse: cover property (UNSUP);
	c_rev_read: cover property (rv);
endmodule
bind pir_identity pir_identity_props u_props (.*);

// ### testbench/pir_nvm_model.sv
// non-volatile byte behind the maker revision
`timescale 1ns/100ps
module pir_nvm_model
(
	input wire logic clk, // clock
	input wire logic store, // write pulse
	input wire logic [7:0] din, // value to keep
	output logic [7:0] dout // kept value
);
	// never cleared by reset, so the value outlives a reset of the bank
	initial dout = 8'h00;
	always @(posedge clk)
		if (store)
			dout <= din;
endmodule

// ### testbench/pir_identity_test.sv
// self-checking bench for the identity bank
`timescale 1ns/100ps
`include "pir_map.svh"
module pir_identity_test
	import pir_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	pir_cmd_t cmd = '0;
	pir_byte_t wr = '0;
	pir_byte_t rd;
	logic rd_req = 1'b0;
	logic cmd_end = 1'b0;
	logic [2:0] ps = 3'h5;
	logic store;
	logic unsup;
	logic [7:0] ndata;
	logic [7:0] nvm;
	logic [7:0] ro [3] = '{8'h9A, 8'hAD, 8'hAE};
	int miscompares = 0;
	int n_checks = 0;
	always #12.5 clk = ~clk;
	pir_nvm_model nvm_m (.clk(clk), .store(store), .din(ndata), .dout(nvm));
	pir_identity #(.PART_EXT(8'h7E)) dut (.SYS_CLK(clk), .RSTN(rstn), .CMD(cmd), .WR(wr),
		.RD_REQ(rd_req), .CMD_END(cmd_end), .NVM_REV(nvm), .PS_DIE_ID(ps), .RD(rd),
		.UNSUP(unsup), .NVM_STORE(store), .NVM_DATA(ndata));
	task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
		n_checks++;
		if (got !== exp)
		begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask
	task automatic go(input pir_cmd_t c, input pir_byte_t w, input logic r, input logic e);
		@(posedge clk);
		cmd <= c;
		wr <= w;
		rd_req <= r;
		cmd_end <= e;
		@(posedge clk);
		{cmd, wr, rd_req, cmd_end} <= '0;
		#1;
	endtask
	task automatic rdblk(input logic [7:0] code, input logic [63:0] b, input int n);
		go({2'b11, code}, '0, 1'b0, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			go('0, '0, 1'b1, 1'b0);
			chk("read byte", {1'b1, b[8*i+:8]}, rd);
		end
		go('0, '0, 1'b0, 1'b1);
	endtask
	// e: refusal after start, store after stop, refusal after stop
	task automatic wrblk(input logic [7:0] code, cnt, v, input logic [2:0] e);
		go({2'b10, code}, '0, 1'b0, 1'b0);
		chk("refusal", {8'h0, e[2]}, {8'h0, unsup});
		go('0, {1'b1, cnt}, 1'b0, 1'b0);
		go('0, {1'b1, v}, 1'b0, 1'b0);
		go('0, '0, 1'b0, 1'b1);
		chk("close", {e[1:0], 7'h0}, {store, unsup, 7'h0});
	endtask
	task automatic rst(input logic [2:0] p);
		@(posedge clk);
		rstn <= 1'b0;
		ps <= p;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	task automatic stop_test();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		rst(3'h5);
		rdblk(`PIR_CMD_MODEL, 64'hFF7E56341204, 6);
		rdblk(`PIR_CMD_IC_ID, 64'h7E563412424106, 7);
		rdblk(`PIR_CMD_SI_REV, 64'h5001, 2);
		rdblk(`PIR_CMD_MAKER_REV, 64'h0001, 2);
		$display("test reads done");
		wrblk(`PIR_CMD_MAKER_REV, 8'h01, 8'hC3, 3'b010);
		wrblk(`PIR_CMD_MAKER_REV, 8'h02, 8'h3C, 3'b001);
		foreach (ro[i]) wrblk(ro[i], 8'h01, 8'h99, 3'b100);
		wrblk(8'h99, 8'h01, 8'h5A, 3'b100);
		go({2'b11, 8'h99}, '0, 1'b0, 1'b0);
		chk("unknown read refusal", 9'h001, {8'h0, unsup});
		go('0, '0, 1'b1, 1'b0);
		chk("unknown read answer", 9'h000, {rd.stb, 8'h0});
		go('0, '0, 1'b0, 1'b1);
		rdblk(`PIR_CMD_MAKER_REV, 64'hC301, 2);
		rdblk(`PIR_CMD_MODEL, 64'h7E56341204, 5);
		$display("test writes done");
		rst(3'h2);
		rdblk(`PIR_CMD_MAKER_REV, 64'hC301, 2);
		rdblk(`PIR_CMD_SI_REV, 64'h2001, 2);
		$display("test retention done");
		stop_test();
	end
	initial
	begin
		// the tests need about 4 us, so 20 us only trips on a hang
		#20us;
		miscompares++;
		stop_test();
	end
endmodule
